// [bench/cgc_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected t=%0t got %h want %h", $time, a, b); end end
module cgc_bench;
    import cgc_pkg::*;
    logic clk_sys, rst_b, slow_clock, main_clock, osc_cfg_write, osc_cfg_enable, osc_cfg_bypass;
    logic pll_cfg_write, main_osc_enable, osc_bypass_select, main_osc_stable, slow_clock_selected;
    logic freq_measure_ready, pll_enable, pll_input_enable, pll_lock;
    logic [7:0] osc_cfg_count, pll_cfg_divider, pll_divider;
    logic [10:0] pll_cfg_factor, pll_feedback_factor;
    logic [5:0] pll_cfg_settle;
    logic [15:0] main_freq_count;
    int fail_count, total_checks, n;
    // divider, factor, settle, expected pll_enable and pll_input_enable
    logic [26:0] rows [4] = '{{8'h00, 11'h000, 6'h02, 2'b00}, {8'h01, 11'h7ff, 6'h02, 2'b11},
        {8'hff, 11'h001, 6'h01, 2'b11}, {8'h00, 11'h005, 6'h03, 2'b10}};
    cgc_top u_cgc_top (.*);
    cgc_osc_model u_cgc_osc_model (.run(main_osc_enable | osc_bypass_select),
        .slow_clock(slow_clock), .main_clock(main_clock));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out
    task automatic wait_hi(input int sel, input int lim, output int k);
        k = 0;
        while ((sel == 0 ? main_osc_stable : sel == 1 ? freq_measure_ready : pll_lock) !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            k++;
            if (k > lim) begin
                fail_count++;
                close_out();
            end
        end
    endtask : wait_hi
    task automatic osc_wr(input logic e, input logic b, input logic [7:0] c);
        @(posedge clk_sys);
        osc_cfg_write <= 1'b1;
        osc_cfg_enable <= e;
        osc_cfg_bypass <= b;
        osc_cfg_count <= c;
        @(posedge clk_sys);
        osc_cfg_write <= 1'b0;
        #1;
    endtask : osc_wr
    task automatic pll_wr(input logic [7:0] d, input logic [10:0] f, input logic [5:0] s);
        @(posedge clk_sys);
        pll_cfg_write <= 1'b1;
        pll_cfg_divider <= d;
        pll_cfg_factor <= f;
        pll_cfg_settle <= s;
        @(posedge clk_sys);
        pll_cfg_write <= 1'b0;
        #1;
    endtask : pll_wr
    initial begin
        {rst_b, osc_cfg_write, osc_cfg_enable, osc_cfg_bypass, osc_cfg_count} = 12'h000;
        {pll_cfg_write, pll_cfg_divider, pll_cfg_factor, pll_cfg_settle} = 26'h000_0000;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        #1;
        `CHK({main_osc_enable, slow_clock_selected, pll_divider}, 10'h100)
        $display("test reset done");
        foreach (rows[i]) begin
            pll_wr(rows[i][26:19], rows[i][18:8], rows[i][7:2]);
            `CHK({pll_divider, pll_feedback_factor}, rows[i][26:8])
            `CHK({pll_enable, pll_input_enable, pll_lock}, {rows[i][1:0], 1'b0})
            if (rows[i][1]) begin
                wait_hi(2, 600, n);
                `CHK(n + 22 >= rows[i][7:2] * 20 && n <= rows[i][7:2] * 20 + 6, 1'b1)
            end
        end
        pll_wr(8'h00, 11'h005, 6'h03);
        `CHK(pll_lock, 1'b0)
        $display("test pll done");
        osc_wr(1'b1, 1'b0, 8'h01);
        wait_hi(0, 800, n);
        `CHK(n >= 136 && n <= 166 && !slow_clock_selected, 1'b1)
        wait_hi(1, 500, n);
        `CHK(main_freq_count >= 16'h003d && main_freq_count <= 16'h0041, 1'b1)
        osc_wr(1'b0, 1'b1, 8'h00);
        repeat (400) @(posedge clk_sys);
        `CHK({main_osc_enable, osc_bypass_select, main_osc_stable, freq_measure_ready}, 4'h4)
        $display("test oscillator done");
        osc_wr(1'b1, 1'b0, 8'h00);
        wait_hi(0, 800, n);
        `CHK(n >= 136 && n <= 166, 1'b1)
        pll_wr(8'h05, 11'h003, 6'h01);
        wait_hi(2, 600, n);
        rst_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHK({main_osc_enable, osc_bypass_select, slow_clock_selected, pll_divider}, 11'h100)
        `CHK({pll_lock, pll_enable, pll_input_enable, pll_feedback_factor}, 14'h0000)
        `CHK({main_osc_stable, freq_measure_ready, main_freq_count}, 18'h0_0000)
        $display("test mid-run reset done");
        close_out();
    end
endmodule : cgc_bench
`default_nettype wire

// [bench/cgc_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module cgc_chk (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic osc_cfg_write,
    input wire logic osc_cfg_enable,
    input wire logic osc_cfg_bypass,
    input wire logic pll_cfg_write,
    input wire logic [7:0] pll_cfg_divider,
    input wire logic [10:0] pll_cfg_factor,
    input wire logic main_osc_enable,
    input wire logic osc_bypass_select,
    input wire logic main_osc_stable,
    input wire logic slow_clock_selected,
    input wire logic freq_measure_ready,
    input wire logic [15:0] main_freq_count,
    input wire logic [7:0] pll_divider,
    input wire logic [10:0] pll_feedback_factor,
    input wire logic pll_enable,
    input wire logic pll_input_enable,
    input wire logic pll_lock
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_osc_off;
        osc_cfg_write && !osc_cfg_enable;
    endsequence
    sequence s_pll_wr;
        pll_cfg_write;
    endsequence
    AST_RST: assert property ($rose(rst_b) |-> !main_osc_enable && slow_clock_selected
        && pll_divider == 8'h00 && !pll_lock) else $error("reset state wrong");
    AST_OSC_OFF: assert property (s_osc_off |=> !main_osc_stable && !main_osc_enable)
        else $error("stable kept after disable");
    AST_OSC_WR: assert property (osc_cfg_write |=> !main_osc_stable
        && main_osc_enable == $past(osc_cfg_enable) && osc_bypass_select == $past(osc_cfg_bypass))
        else $error("oscillator write not taken");
    AST_SEL: assert property (slow_clock_selected == !main_osc_stable)
        else $error("clock select wrong");
    AST_STABLE: assert property ($rose(main_osc_stable) |-> main_osc_enable
        && !$past(osc_cfg_write)) else $error("stable without countdown");
    AST_READY: assert property (freq_measure_ready |-> main_osc_stable)
        else $error("ready without stable");
    AST_FREEZE: assert property (freq_measure_ready && !osc_cfg_write |=> freq_measure_ready
        && $stable(main_freq_count)) else $error("count moved after ready");
    AST_PLL_WR: assert property (s_pll_wr |=> !pll_lock && pll_divider == $past(pll_cfg_divider)
        && pll_feedback_factor == $past(pll_cfg_factor) && pll_enable == ($past(pll_cfg_factor) != 0)
        && pll_input_enable == ($past(pll_cfg_divider) != 0)) else $error("pll write not taken");
    AST_LOCK: assert property ($rose(pll_lock) |-> pll_enable && !$past(pll_cfg_write))
        else $error("lock without countdown");
endmodule : cgc_chk
bind cgc_top cgc_chk u_cgc_chk (.*);
`default_nettype wire

// [bench/cgc_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cgc_osc_model (
    input wire logic run,
    output logic slow_clock,
    output logic main_clock
);
    // slow clock never stops, main clock only while crystal or bypass feed runs
    initial begin
        slow_clock = 1'b0;
        forever #50 slow_clock = ~slow_clock;
    end
    initial begin
        main_clock = 1'b0;
        forever #12.5 main_clock = run ? ~main_clock : 1'b0;
    end
endmodule : cgc_osc_model
`default_nettype wire

// [rtl/cgc_pkg.sv]
package cgc_pkg;

    localparam int unsigned CGC_OSC_COUNT_W = 8;
    localparam int unsigned CGC_DIV_W = 8;
    localparam int unsigned CGC_FACTOR_W = 11;
    localparam int unsigned CGC_SETTLE_W = 6;
    localparam int unsigned CGC_FREQ_W = 16;
    localparam int unsigned CGC_PRESCALE_W = 3;
    localparam int unsigned CGC_PERIODS_W = 5;

    // startup countdown steps on every eighth slow clock rising edge
    localparam logic [CGC_PRESCALE_W-1:0] CGC_PRESCALE_LAST = 3'h7;
    // measurement window closes at this falling edge count
    localparam logic [CGC_PERIODS_W-1:0] CGC_MEAS_PERIODS = 5'h10;

    localparam logic [CGC_OSC_COUNT_W-1:0] CGC_OSC_COUNT_RST = 8'h00;
    localparam logic [CGC_DIV_W-1:0] CGC_DIV_RST = 8'h00;
    localparam logic [CGC_FACTOR_W-1:0] CGC_FACTOR_RST = 11'h000;
    localparam logic [CGC_SETTLE_W-1:0] CGC_SETTLE_RST = 6'h00;
    localparam logic [CGC_FREQ_W-1:0] CGC_FREQ_RST = 16'h0000;
    localparam logic [CGC_FREQ_W-1:0] CGC_FREQ_MAX = 16'hffff;

    typedef enum logic [1:0] {
        CGC_MEAS_IDLE,
        CGC_MEAS_WAIT_RISE,
        CGC_MEAS_COUNT,
        CGC_MEAS_DONE
    } cgc_meas_t;

    typedef struct packed {
        logic [2:0] slow_sync;
        logic [2:0] main_sync;
        logic main_osc_enable;
        logic osc_bypass_select;
        logic osc_counting;
        logic [CGC_OSC_COUNT_W-1:0] osc_startup_count;
        logic [CGC_PRESCALE_W-1:0] prescale;
        logic main_osc_stable;
        logic slow_clock_selected;
        cgc_meas_t meas_state;
        logic [CGC_PERIODS_W-1:0] fall_count;
        logic [CGC_FREQ_W-1:0] main_freq_count;
        logic freq_measure_ready;
        logic [CGC_DIV_W-1:0] pll_divider;
        logic [CGC_FACTOR_W-1:0] pll_feedback_factor;
        logic pll_enable;
        logic pll_input_enable;
        logic pll_counting;
        logic [CGC_SETTLE_W-1:0] pll_settle_count;
        logic pll_lock;
    } cgc_state_t;

endpackage : cgc_pkg

// [rtl/cgc_top.sv]
// Functional notes
// [R1] three clocks: free slow clock, main oscillator clock, divider and pll clock
// [R2] reset leaves main oscillator off and slow clock selected
// [R3] clearing oscillator enable clears the stable flag
// [R4] enable write clears stable, counts down from value at slow clock over 8
// [R5] startup count field is 8 bits, about 62 ms at most
// [R6] countdown at zero sets stable flag, which may interrupt
// [R7] software loads startup count matching the crystal startup time
// [R8] frequency counting starts at slow rising edge after stable is set
// [R9] sixteenth slow falling edge stops counter and sets ready flag
// [R10] frequency value is main cycles in 16 slow clock periods
// [R11] external clock use: software sets bypass 1 and enable 0
// [R12] software picks divider respecting pll minimum input frequency
// [R13] divider accepts every integer 1 to 255
// [R14] divider zero holds divider and pll output low; code only clears pll_input_enable, pll_enable and lock follow factor
// [R15] reset sets divider to zero, stopping pll input clock
// [R16] pll output is source times factor plus one over divider
// [R17] factor zero powers pll down, nonzero re-enables it
// [R18] re-enable or parameter change clears the lock flag
// [R19] pll write loads settle count, decremented on slow clock, zero sets lock
// [R20] software sets settle count to cover pll transient time
// [R21] pll factor field is 11 bits, 0 through 2047
// [R22] flags are held levels presented to power status logic
`timescale 1ns/1ps
`default_nettype none

module cgc_top
    import cgc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic slow_clock,
    input wire logic main_clock,
    input wire logic osc_cfg_write,
    input wire logic osc_cfg_enable,
    input wire logic osc_cfg_bypass,
    input wire logic [CGC_OSC_COUNT_W-1:0] osc_cfg_count,
    input wire logic pll_cfg_write,
    input wire logic [CGC_DIV_W-1:0] pll_cfg_divider,
    input wire logic [CGC_FACTOR_W-1:0] pll_cfg_factor,
    input wire logic [CGC_SETTLE_W-1:0] pll_cfg_settle,
    output logic main_osc_enable,
    output logic osc_bypass_select,
    output logic main_osc_stable,
    output logic slow_clock_selected,
    output logic freq_measure_ready,
    output logic [CGC_FREQ_W-1:0] main_freq_count,
    output logic [CGC_DIV_W-1:0] pll_divider,
    output logic [CGC_FACTOR_W-1:0] pll_feedback_factor,
    output logic pll_enable,
    output logic pll_input_enable,
    output logic pll_lock
);

    cgc_state_t state;
    cgc_state_t next_state;

    logic slow_rise;
    logic slow_fall;
    logic main_rise;
    logic osc_tick;

    // edges seen only from the second and third sync stages
    assign slow_rise = state.slow_sync[1] & ~state.slow_sync[2];
    assign slow_fall = ~state.slow_sync[1] & state.slow_sync[2];
    assign main_rise = state.main_sync[1] & ~state.main_sync[2];
    assign osc_tick = slow_rise && (state.prescale == CGC_PRESCALE_LAST); // [R4]

    always_comb begin
        next_state = state;
        next_state.slow_sync = {state.slow_sync[1:0], slow_clock};
        next_state.main_sync = {state.main_sync[1:0], main_clock};

        // main oscillator startup
        if (state.osc_counting && slow_rise) begin
            next_state.prescale = state.prescale + 3'h1;
        end
        // stable is set on the tick that brings the count to zero, a loaded zero ends on the first tick
        if (state.osc_counting && osc_tick) begin
            next_state.osc_startup_count = state.osc_startup_count - 8'h01; // [R4]
            if (state.osc_startup_count == CGC_OSC_COUNT_RST) begin
                next_state.osc_startup_count = CGC_OSC_COUNT_RST;
            end
            if (next_state.osc_startup_count == CGC_OSC_COUNT_RST) begin
                next_state.main_osc_stable = 1'b1; // [R6]
                next_state.osc_counting = 1'b0;
            end
        end
        if (osc_cfg_write) begin
            next_state.main_osc_enable = osc_cfg_enable;
            next_state.osc_bypass_select = osc_cfg_bypass;
            next_state.osc_startup_count = osc_cfg_count; // [R5]
            next_state.prescale = '0;
            next_state.main_osc_stable = 1'b0; // [R3] [R4]
            next_state.osc_counting = osc_cfg_enable; // [R4]
        end
        next_state.slow_clock_selected = ~next_state.main_osc_stable; // [R1] [R2]

        // main clock frequency measurement
        case (state.meas_state)
            CGC_MEAS_IDLE: begin
                if (state.main_osc_stable) begin
                    next_state.meas_state = CGC_MEAS_WAIT_RISE; // [R8]
                end
            end
            CGC_MEAS_WAIT_RISE: begin
                if (slow_rise) begin
                    next_state.meas_state = CGC_MEAS_COUNT; // [R8]
                    next_state.fall_count = '0;
                    next_state.main_freq_count = CGC_FREQ_RST;
                end
            end
            CGC_MEAS_COUNT: begin
                if (main_rise && state.main_freq_count != CGC_FREQ_MAX) begin
                    next_state.main_freq_count = state.main_freq_count + 16'h0001; // [R10]
                end
                if (slow_fall) begin
                    next_state.fall_count = state.fall_count + 5'h01;
                    if (state.fall_count + 5'h01 == CGC_MEAS_PERIODS) begin
                        next_state.meas_state = CGC_MEAS_DONE; // [R9]
                        next_state.freq_measure_ready = 1'b1; // [R9] [R22]
                    end
                end
            end
            CGC_MEAS_DONE: begin
                next_state.meas_state = CGC_MEAS_DONE;
            end
            default: begin
                next_state.meas_state = CGC_MEAS_IDLE;
            end
        endcase
        if (!next_state.main_osc_stable) begin
            next_state.meas_state = CGC_MEAS_IDLE;
            next_state.freq_measure_ready = 1'b0;
        end

        // divider and pll
        // lock is set on the slow rise that brings the count to zero
        if (state.pll_counting && slow_rise) begin
            next_state.pll_settle_count = state.pll_settle_count - 6'h01; // [R19]
            if (state.pll_settle_count == CGC_SETTLE_RST) begin
                next_state.pll_settle_count = CGC_SETTLE_RST;
            end
            if (next_state.pll_settle_count == CGC_SETTLE_RST) begin
                next_state.pll_lock = 1'b1; // [R19] [R22]
                next_state.pll_counting = 1'b0;
            end
        end
        if (pll_cfg_write) begin
            next_state.pll_divider = pll_cfg_divider; // [R13]
            next_state.pll_feedback_factor = pll_cfg_factor; // [R16] [R21]
            next_state.pll_enable = (pll_cfg_factor != CGC_FACTOR_RST); // [R17]
            next_state.pll_input_enable = (pll_cfg_divider != CGC_DIV_RST); // [R14]
            next_state.pll_lock = 1'b0; // [R18]
            next_state.pll_settle_count = pll_cfg_settle; // [R19]
            next_state.pll_counting = (pll_cfg_factor != CGC_FACTOR_RST); // [R17]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= '0;
            state.main_osc_enable <= 1'b0; // [R2]
            state.slow_clock_selected <= 1'b1; // [R2]
            state.osc_startup_count <= CGC_OSC_COUNT_RST;
            state.pll_divider <= CGC_DIV_RST; // [R15]
            state.pll_feedback_factor <= CGC_FACTOR_RST;
            state.pll_settle_count <= CGC_SETTLE_RST;
            state.main_freq_count <= CGC_FREQ_RST;
            state.meas_state <= CGC_MEAS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    assign main_osc_enable = state.main_osc_enable;
    assign osc_bypass_select = state.osc_bypass_select;
    assign main_osc_stable = state.main_osc_stable;
    assign slow_clock_selected = state.slow_clock_selected;
    assign freq_measure_ready = state.freq_measure_ready;
    assign main_freq_count = state.main_freq_count;
    assign pll_divider = state.pll_divider;
    assign pll_feedback_factor = state.pll_feedback_factor;
    assign pll_enable = state.pll_enable;
    assign pll_input_enable = state.pll_input_enable;
    assign pll_lock = state.pll_lock;

endmodule : cgc_top

`default_nettype wire
